/* hdl/tlpc_defs.svh */
// field positions, encodings and limits for the received packet format checker
`ifndef TLPC_DEFS_SVH
`define TLPC_DEFS_SVH

// header vector: dw0 in [127:96], dw1 in [95:64], dw2 in [63:32], dw3 in [31:0]
`define TLPC_HDR_W 128
`define TLPC_DWCNT_W 11
`define TLPC_STAT_W 16
`define TLPC_FUNC_CNT_W 4

// dw0 fields
`define TLPC_FMT_DATA 126
`define TLPC_FMT_4DW 125
`define TLPC_TYPE 124:120
`define TLPC_TC 118:116
`define TLPC_TD 111
`define TLPC_ATTR 109:108
`define TLPC_AT 107:106
`define TLPC_LEN 105:96

// dw1 fields, plus the upper type bits from dw0
`define TLPC_TAG 79:72
`define TLPC_LBE 71:68
`define TLPC_FBE 67:64
`define TLPC_MSG_CODE 71:64
`define TLPC_TAG_HI 79:77
`define TLPC_INTX_CODE 71:67
`define TLPC_TYPE_HI2 124:123
`define TLPC_TYPE_HI4 124:121

// dw2 and dw3 fields
`define TLPC_CFG_FUNC 50:48
`define TLPC_ADDR32_DW 43:34
`define TLPC_ADDR64_DW 11:2
`define TLPC_ADDR32_QW 34
`define TLPC_ADDR64_QW 2

// type encodings
`define TLPC_TYPE_MEM 5'h00
`define TLPC_TYPE_IO 5'h02
`define TLPC_TYPE_CFG0 5'h04
`define TLPC_TYPE_CFG1 5'h05
`define TLPC_TYPE_MSG_HI 2'h2
`define TLPC_TYPE_CPL_HI 4'h5
`define TLPC_INTX_CODE_HI 5'h04

// field values
`define TLPC_TC_ZERO 3'h0
`define TLPC_ATTR_ZERO 2'h0
`define TLPC_AT_ZERO 2'h0
`define TLPC_LEN_ONE 10'h001
`define TLPC_LEN_ZERO 10'h000
`define TLPC_LEN_MAX 11'h400
`define TLPC_BE_NONE 4'h0
`define TLPC_BE_ALL 4'hF
`define TLPC_TAG_EXT_BITS 3'h0
`define TLPC_PAGE_DW 11'h400
`define TLPC_DW_ZERO 11'h000
`define TLPC_DW_ONE 11'h001
`define TLPC_DW_TWO 11'h002
`define TLPC_STAT_MAX 16'hFFFF
`define TLPC_STAT_ONE 16'h0001

`endif

/* hdl/tlpc_pkg.sv */
// types and shared header checks for the received packet format checker
`include "tlpc_defs.svh"

package tlpc_pkg;

   typedef enum logic [2:0] {
      TLPC_CAUSE_NONE = 3'b000,
      TLPC_CAUSE_DIGEST = 3'b001,
      TLPC_CAUSE_TAG = 3'b010,
      TLPC_CAUSE_CROSS = 3'b011,
      TLPC_CAUSE_IO = 3'b100,
      TLPC_CAUSE_CFG = 3'b101,
      TLPC_CAUSE_FUNC = 3'b110,
      TLPC_CAUSE_INTX = 3'b111
   } tlpc_cause_t;

   // length field of zero means the largest packet
   function automatic logic [`TLPC_DWCNT_W-1:0] tlpc_len_dw(input logic [`TLPC_HDR_W-1:0] hdr);
      tlpc_len_dw = (hdr[`TLPC_LEN] == `TLPC_LEN_ZERO) ? `TLPC_LEN_MAX : {1'b0, hdr[`TLPC_LEN]};
   endfunction

   function automatic logic [9:0] tlpc_addr_dw(input logic [`TLPC_HDR_W-1:0] hdr);
      tlpc_addr_dw = hdr[`TLPC_FMT_4DW] ? hdr[`TLPC_ADDR64_DW] : hdr[`TLPC_ADDR32_DW];
   endfunction

   function automatic logic tlpc_is_req(input logic [`TLPC_HDR_W-1:0] hdr);
      tlpc_is_req = (hdr[`TLPC_TYPE_HI2] != `TLPC_TYPE_MSG_HI) && (hdr[`TLPC_TYPE_HI4] != `TLPC_TYPE_CPL_HI);
   endfunction

   function automatic logic tlpc_cross_4k(input logic [`TLPC_HDR_W-1:0] hdr);
      logic [`TLPC_DWCNT_W:0] last;
      last = {2'b00, tlpc_addr_dw(hdr)} + {1'b0, tlpc_len_dw(hdr)};
      tlpc_cross_4k = last > {1'b0, `TLPC_PAGE_DW};
   endfunction

   // short tags leave the upper three bits clear
   function automatic logic tlpc_tag_bad(input logic [`TLPC_HDR_W-1:0] hdr, input logic ext_en);
      tlpc_tag_bad = tlpc_is_req(hdr) && !ext_en && (hdr[`TLPC_TAG_HI] != `TLPC_TAG_EXT_BITS);
   endfunction

   function automatic logic tlpc_ioc_bad(input logic [`TLPC_HDR_W-1:0] hdr);
      tlpc_ioc_bad = (hdr[`TLPC_TC] != `TLPC_TC_ZERO) || (hdr[`TLPC_ATTR] != `TLPC_ATTR_ZERO) ||
         (hdr[`TLPC_AT] != `TLPC_AT_ZERO) || (hdr[`TLPC_LEN] != `TLPC_LEN_ONE) ||
         (hdr[`TLPC_LBE] != `TLPC_BE_NONE);
   endfunction

   function automatic logic tlpc_contig(input logic [3:0] be, input logic low_side);
      if (low_side) begin
         tlpc_contig = (be == 4'h1) || (be == 4'h3) || (be == 4'h7) || (be == `TLPC_BE_ALL);
      end else begin
         tlpc_contig = (be == 4'h8) || (be == 4'hC) || (be == 4'hE) || (be == `TLPC_BE_ALL);
      end
   endfunction

   function automatic logic tlpc_be_bad(input logic [`TLPC_HDR_W-1:0] hdr);
      logic [`TLPC_DWCNT_W-1:0] n;
      logic qw_off;
      logic [3:0] fbe;
      logic [3:0] lbe;
      n = tlpc_len_dw(hdr);
      qw_off = hdr[`TLPC_FMT_4DW] ? hdr[`TLPC_ADDR64_QW] : hdr[`TLPC_ADDR32_QW];
      fbe = hdr[`TLPC_FBE];
      lbe = hdr[`TLPC_LBE];
      tlpc_be_bad = 1'b0;
      if (n == `TLPC_DW_ONE) begin
         tlpc_be_bad = lbe != `TLPC_BE_NONE;
      end else begin
         if ((fbe == `TLPC_BE_NONE) || (lbe == `TLPC_BE_NONE)) begin
            tlpc_be_bad = 1'b1;
         end
         if ((n > `TLPC_DW_TWO) || qw_off) begin
            if (!tlpc_contig(fbe, 1'b0) || !tlpc_contig(lbe, 1'b1)) begin
               tlpc_be_bad = 1'b1;
            end
         end
      end
   endfunction

endpackage

/* hdl/tlpc_if.sv */
// packet descriptor channel from the checking end to the user end
`timescale 1ns/1ps
`default_nettype none
`include "tlpc_defs.svh"

interface tlpc_if;
   logic valid;
   logic ready;
   logic [`TLPC_HDR_W-1:0] hdr;
   logic [`TLPC_DWCNT_W-1:0] rcv_dw;

   modport dev (
      output valid,
      output hdr,
      output rcv_dw,
      input ready
   );

   modport usr (
      input valid,
      input hdr,
      input rcv_dw,
      output ready
   );
endinterface

`default_nettype wire

/* hdl/tlpc_dev_end.sv */
// device end: checks the format of received packets and forwards the good ones
//
// Overview of operation
// - digest present exactly when TD set
// - user: multi-dw packet, first BE nonzero
// - user: single-dw packet, last BE zero
// - user: multi-dw packet, last BE nonzero
// - user: byte enables contiguous where required
// - request tag width matches configuration
// - user checks tag width both directions
// - memory write must not cross 4 KB
// - user may check reads for 4 KB
// - I/O request TC, attr, AT zero
// - I/O request length one, last BE zero
// - config request TC, attr, AT zero
// - config request length one, last BE zero
// - config request targets existing function
// - INTx messages only from upstream ports
// - device checks received, user checks transmitted and also rechecks received BE, tag and read page
`timescale 1ns/1ps
`default_nettype none
`include "tlpc_defs.svh"

module tlpc_dev_end
   import tlpc_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // received packets from the link side
   input wire logic rx_valid,
   output logic rx_ready,
   input wire logic [`TLPC_HDR_W-1:0] rx_hdr,
   input wire logic [`TLPC_DWCNT_W-1:0] rx_rcv_dw,
   // configuration levels
   input wire logic cfg_ext_tag_en,
   input wire logic [`TLPC_FUNC_CNT_W-1:0] cfg_func_count,
   input wire logic cfg_downstream_port,
   // error report
   output logic err_malformed,
   output tlpc_cause_t err_cause,
   output logic [`TLPC_HDR_W-1:0] err_hdr,
   // statistics
   output logic [`TLPC_STAT_W-1:0] stat_fwd_count,
   output logic [`TLPC_STAT_W-1:0] stat_mal_count,
   // towards the user end
   tlpc_if.dev usr
);

   typedef struct packed {
      logic out_valid;
      logic [`TLPC_HDR_W-1:0] out_hdr;
      logic [`TLPC_DWCNT_W-1:0] out_rcv_dw;
      logic err_pulse;
      tlpc_cause_t err_cause;
      logic [`TLPC_HDR_W-1:0] err_hdr;
      logic [`TLPC_STAT_W-1:0] fwd_count;
      logic [`TLPC_STAT_W-1:0] mal_count;
   } tlpc_dev_state_t;

   tlpc_dev_state_t q;
   tlpc_dev_state_t next_q;

   logic take;
   logic [4:0] pkt_type;
   logic has_data;
   logic is_mem_wr;
   logic is_io;
   logic is_cfg;
   logic is_intx;
   logic [`TLPC_DWCNT_W-1:0] exp_dw;
   logic digest_bad;
   logic tag_bad;
   logic cross_bad;
   logic io_bad;
   logic cfg_bad;
   logic func_bad;
   logic intx_bad;
   tlpc_cause_t cause;
   logic is_msg;
   logic [`TLPC_FUNC_CNT_W-1:0] func_num;
   logic [`TLPC_DWCNT_W-1:0] pay_dw;
   logic tc_set;
   logic attr_set;
   logic at_set;
   logic len_not_one;
   logic lbe_set;
   logic ioc_fields_bad;
   logic fwd_sat;
   logic mal_sat;

   // one slot: a new packet is taken while the slot is empty or draining
   assign rx_ready = !q.out_valid || usr.ready;
   assign take = rx_valid && rx_ready;

   assign pkt_type = rx_hdr[`TLPC_TYPE];
   assign has_data = rx_hdr[`TLPC_FMT_DATA];
   assign is_mem_wr = (pkt_type == `TLPC_TYPE_MEM) && has_data;
   assign is_io = pkt_type == `TLPC_TYPE_IO;
   assign is_cfg = (pkt_type == `TLPC_TYPE_CFG0) || (pkt_type == `TLPC_TYPE_CFG1);
   assign is_msg = rx_hdr[`TLPC_TYPE_HI2] == `TLPC_TYPE_MSG_HI;
   assign is_intx = is_msg && (rx_hdr[`TLPC_INTX_CODE] == `TLPC_INTX_CODE_HI);

   assign pay_dw = has_data ? tlpc_len_dw(rx_hdr) : `TLPC_DW_ZERO;
   assign exp_dw = pay_dw + {10'h000, rx_hdr[`TLPC_TD]};
   assign digest_bad = rx_rcv_dw != exp_dw;

   assign tag_bad = tlpc_tag_bad(rx_hdr, cfg_ext_tag_en);

   assign cross_bad = is_mem_wr && tlpc_cross_4k(rx_hdr);

   assign tc_set = rx_hdr[`TLPC_TC] != `TLPC_TC_ZERO;
   assign attr_set = rx_hdr[`TLPC_ATTR] != `TLPC_ATTR_ZERO;
   assign at_set = rx_hdr[`TLPC_AT] != `TLPC_AT_ZERO;
   assign len_not_one = rx_hdr[`TLPC_LEN] != `TLPC_LEN_ONE;
   assign lbe_set = rx_hdr[`TLPC_LBE] != `TLPC_BE_NONE;
   assign ioc_fields_bad = tc_set || attr_set || at_set || len_not_one || lbe_set;

   assign io_bad = is_io && ioc_fields_bad;

   assign cfg_bad = is_cfg && ioc_fields_bad;

   assign func_num = {1'b0, rx_hdr[`TLPC_CFG_FUNC]};
   assign func_bad = is_cfg && (func_num >= cfg_func_count);

   // INTx only toward a downstream port
   assign intx_bad = is_intx && !cfg_downstream_port;

   // counters saturate so a flood of traffic never wraps to a small value
   assign fwd_sat = q.fwd_count == `TLPC_STAT_MAX;
   assign mal_sat = q.mal_count == `TLPC_STAT_MAX;

   // the digest check wins: a length mismatch makes the other fields untrustworthy
   always_comb begin
      cause = TLPC_CAUSE_NONE;
      if (digest_bad) begin
         cause = TLPC_CAUSE_DIGEST;
      end else if (io_bad) begin
         cause = TLPC_CAUSE_IO;
      end else if (cfg_bad) begin
         cause = TLPC_CAUSE_CFG;
      end else if (func_bad) begin
         cause = TLPC_CAUSE_FUNC;
      end else if (cross_bad) begin
         cause = TLPC_CAUSE_CROSS;
      end else if (tag_bad) begin
         cause = TLPC_CAUSE_TAG;
      end else if (intx_bad) begin
         cause = TLPC_CAUSE_INTX;
      end
   end

   always_comb begin
      next_q = q;
      next_q.err_pulse = 1'b0;
      if (q.out_valid && usr.ready) begin
         next_q.out_valid = 1'b0;
      end
      if (take) begin
         if (cause != TLPC_CAUSE_NONE) begin
            next_q.err_pulse = 1'b1;
            next_q.err_cause = cause;
            next_q.err_hdr = rx_hdr;
            if (!mal_sat) begin
               next_q.mal_count = q.mal_count + `TLPC_STAT_ONE;
            end
         end else begin
            next_q.out_valid = 1'b1;
            next_q.out_hdr = rx_hdr;
            next_q.out_rcv_dw = rx_rcv_dw;
            if (!fwd_sat) begin
               next_q.fwd_count = q.fwd_count + `TLPC_STAT_ONE;
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   // outputs other than rx_ready come straight from state; the error pulse lasts one cycle
   assign usr.valid = q.out_valid;
   assign usr.hdr = q.out_hdr;
   assign usr.rcv_dw = q.out_rcv_dw;
   assign err_malformed = q.err_pulse;
   assign err_cause = q.err_cause;
   assign err_hdr = q.err_hdr;
   assign stat_fwd_count = q.fwd_count;
   assign stat_mal_count = q.mal_count;

endmodule

`default_nettype wire

/* hdl/tlpc_usr_end.sv */
// user end: optional byte enable and read page checks plus a tag check on received packets; byte enable, page, I/O-config and tag checks on transmitted headers
`timescale 1ns/1ps
`default_nettype none
`include "tlpc_defs.svh"

module tlpc_usr_end
   import tlpc_pkg::*;
#(
   parameter bit CHK_BE = 1'b1,
   parameter bit CHK_RD_4K = 1'b1
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // from the checking end
   tlpc_if.usr dev,
   // configuration level
   input wire logic cfg_ext_tag_en,
   // received packets to the application
   output logic app_valid,
   input wire logic app_ready,
   output logic [`TLPC_HDR_W-1:0] app_hdr,
   output logic [`TLPC_DWCNT_W-1:0] app_rcv_dw,
   output logic usr_malformed,
   // transmit header check
   input wire logic tx_valid,
   input wire logic [`TLPC_HDR_W-1:0] tx_hdr,
   output logic tx_chk_done,
   output logic tx_chk_bad
);

   typedef struct packed {
      logic app_valid;
      logic [`TLPC_HDR_W-1:0] app_hdr;
      logic [`TLPC_DWCNT_W-1:0] app_rcv_dw;
      logic mal_pulse;
      logic tx_done;
      logic tx_bad;
   } tlpc_usr_state_t;

   tlpc_usr_state_t q;
   tlpc_usr_state_t next_q;

   logic take;
   logic rx_mem;
   logic rx_bad;
   logic tx_mem;
   logic tx_ioc;
   logic tx_bad;

   assign dev.ready = !q.app_valid || app_ready;
   assign take = dev.valid && dev.ready;
   assign rx_mem = dev.hdr[`TLPC_TYPE] == `TLPC_TYPE_MEM;

   // byte enables, tag, read page crossing
   assign rx_bad = (CHK_BE && rx_mem && tlpc_be_bad(dev.hdr)) ||
      tlpc_tag_bad(dev.hdr, cfg_ext_tag_en) ||
      (CHK_RD_4K && rx_mem && !dev.hdr[`TLPC_FMT_DATA] && tlpc_cross_4k(dev.hdr));

   assign tx_mem = tx_hdr[`TLPC_TYPE] == `TLPC_TYPE_MEM;
   assign tx_ioc = (tx_hdr[`TLPC_TYPE] == `TLPC_TYPE_IO) || (tx_hdr[`TLPC_TYPE] == `TLPC_TYPE_CFG0) ||
      (tx_hdr[`TLPC_TYPE] == `TLPC_TYPE_CFG1);
   assign tx_bad = (tx_mem && (tlpc_be_bad(tx_hdr) || tlpc_cross_4k(tx_hdr))) ||
      (tx_ioc && tlpc_ioc_bad(tx_hdr)) || tlpc_tag_bad(tx_hdr, cfg_ext_tag_en);

   always_comb begin
      next_q = q;
      next_q.mal_pulse = 1'b0;
      next_q.tx_done = tx_valid;
      next_q.tx_bad = tx_valid && tx_bad;
      if (q.app_valid && app_ready) begin
         next_q.app_valid = 1'b0;
      end
      if (take) begin
         if (rx_bad) begin
            next_q.mal_pulse = 1'b1;
         end else begin
            next_q.app_valid = 1'b1;
            next_q.app_hdr = dev.hdr;
            next_q.app_rcv_dw = dev.rcv_dw;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign app_valid = q.app_valid;
   assign app_hdr = q.app_hdr;
   assign app_rcv_dw = q.app_rcv_dw;
   assign usr_malformed = q.mal_pulse;
   assign tx_chk_done = q.tx_done;
   assign tx_chk_bad = q.tx_bad;

endmodule

`default_nettype wire

/* sim/tlpc_asserts.sv */
// concurrent checks on the descriptor channel joining the two ends
`timescale 1ns/1ps
`default_nettype none
`include "tlpc_defs.svh"

module tlpc_asserts (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // descriptor channel
   input wire logic valid,
   input wire logic ready,
   input wire logic [`TLPC_HDR_W-1:0] hdr,
   input wire logic [`TLPC_DWCNT_W-1:0] rcv_dw
);
   logic [10:0] len;
   logic [11:0] last;
   logic is_io;
   logic is_cfg;
   // a zero length field means a full 1024 dw packet
   assign len = (hdr[`TLPC_LEN] == 10'h000) ? 11'h400 : {1'b0, hdr[`TLPC_LEN]};
   assign last = {2'h0, hdr[125] ? hdr[`TLPC_ADDR64_DW] : hdr[`TLPC_ADDR32_DW]} + {1'h0, len};
   assign is_io = valid && (hdr[`TLPC_TYPE] == 5'h02);
   assign is_cfg = valid && (hdr[124:121] == 4'h2);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);
   a_hold_valid: assert property (valid && !ready |=> valid)
      else $error("descriptor withdrawn before taken");
   a_hold_hdr: assert property (valid && !ready |=> $stable(hdr) && $stable(rcv_dw))
      else $error("descriptor changed while waiting");
   a_digest_match: assert property (valid |-> rcv_dw == (hdr[126] ? len : 11'h0) + {10'h0, hdr[111]})
      else $error("forwarded packet with digest mismatch");
   a_io_fields: assert property (is_io |-> {hdr[118:116], hdr[109:106]} == 7'h00)
      else $error("forwarded io request with nonzero tc attr at");
   a_io_len: assert property (is_io |-> hdr[`TLPC_LEN] == 10'h001 && hdr[`TLPC_LBE] == 4'h0)
      else $error("forwarded io request with bad length or last be");
   a_cfg_fields: assert property (is_cfg |-> {hdr[118:116], hdr[109:106]} == 7'h00)
      else $error("forwarded cfg request with nonzero tc attr at");
   a_cfg_len: assert property (is_cfg |-> hdr[`TLPC_LEN] == 10'h001 && hdr[`TLPC_LBE] == 4'h0)
      else $error("forwarded cfg request with bad length or last be");
   a_write_page: assert property (valid && hdr[126] && hdr[124:120] == 5'h00 |-> last <= 12'h400)
      else $error("forwarded memory write crossing a page");
endmodule

`default_nettype wire

/* sim/tb_tlp_receive_format_checker.sv */
// self-checking bench joining the checking end and the user end
`timescale 1ns/1ps
`default_nettype none
`include "tlpc_defs.svh"

module tb_tlp_receive_format_checker;
   import tlpc_pkg::*;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic rx_valid = 1'b0;
   logic rx_ready;
   logic [127:0] rx_hdr = '0;
   logic [10:0] rx_rcv_dw = '0;
   logic ext_tag = 1'b0;
   logic [3:0] func_cnt = 4'h2;
   logic dn_port = 1'b0;
   logic err_malformed;
   tlpc_cause_t err_cause;
   logic [127:0] err_hdr;
   logic [127:0] app_hdr;
   logic [10:0] app_rcv_dw;
   logic [15:0] fwd_cnt;
   logic [15:0] mal_cnt;
   logic app_valid;
   logic app_ready = 1'b1;
   logic usr_malformed;
   logic tx_valid = 1'b0;
   logic [127:0] tx_hdr = '0;
   logic tx_done;
   logic tx_bad;
   int err_total = 0;
   int n_compared = 0;

   tlpc_if lnk ();
   tlpc_dev_end u_tlpc_dev_end (.core_clk(core_clk), .srst(srst), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .rx_hdr(rx_hdr), .rx_rcv_dw(rx_rcv_dw), .cfg_ext_tag_en(ext_tag), .cfg_func_count(func_cnt),
      .cfg_downstream_port(dn_port), .err_malformed(err_malformed), .err_cause(err_cause), .err_hdr(err_hdr),
      .stat_fwd_count(fwd_cnt), .stat_mal_count(mal_cnt), .usr(lnk));
   tlpc_usr_end u_tlpc_usr_end (.core_clk(core_clk), .srst(srst), .dev(lnk), .cfg_ext_tag_en(ext_tag),
      .app_valid(app_valid), .app_ready(app_ready), .app_hdr(app_hdr), .app_rcv_dw(app_rcv_dw),
      .usr_malformed(usr_malformed),
      .tx_valid(tx_valid), .tx_hdr(tx_hdr), .tx_chk_done(tx_done), .tx_chk_bad(tx_bad));
   tlpc_asserts u_chk (.core_clk(core_clk), .srst(srst), .valid(lnk.valid), .ready(lnk.ready),
      .hdr(lnk.hdr), .rcv_dw(lnk.rcv_dw));

   always #5 core_clk = ~core_clk;

   // ft is fmt and type together, be is last and first byte enables
   function automatic logic [127:0] mk(logic [6:0] ft, logic [9:0] len, logic [7:0] be, logic [9:0] adw);
      mk = '0;
      mk[126:120] = ft;
      mk[`TLPC_LEN] = len;
      mk[71:64] = be;
      mk[43:34] = adw;
   endfunction

   task automatic chk(string nm, logic [127:0] e, logic [127:0] g);
      n_compared++;
      if (g !== e) begin
         $display("mismatch %s expected %0h seen %0h", nm, e, g);
         err_total++;
      end
   endtask

   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // res: 0 reaches the application, 1 dropped by checking end, 2 dropped by user end
   task automatic pkt(logic [127:0] h, logic [10:0] n, int res, tlpc_cause_t c);
      int i;
      i = 0;
      rx_valid = 1'b1;
      rx_hdr = h;
      rx_rcv_dw = n;
      while (rx_ready !== 1'b1 && i < 50) begin
         @(posedge core_clk);
         #1;
         i++;
      end
      chk("rx_ready", 1, rx_ready);
      @(posedge core_clk);
      #1;
      rx_valid = 1'b0;
      chk("err_malformed", res == 1, err_malformed);
      if (res == 1) chk("err_cause", c, err_cause);
      if (res == 1) chk("err_hdr", h, err_hdr);
      @(posedge core_clk);
      #1;
      chk("app_valid", res == 0, app_valid);
      chk("usr_malformed", res == 2, usr_malformed);
      if (res == 0) chk("app_hdr", h, app_hdr);
      if (res == 0) chk("app_rcv_dw", n, app_rcv_dw);
   endtask

   task automatic t_digest();
      logic [127:0] h;
      h = mk(7'h40, 10'h001, 8'h0F, 10'h0);
      pkt(h, 11'h001, 0, TLPC_CAUSE_NONE);
      h[111] = 1'b1;
      pkt(h, 11'h002, 0, TLPC_CAUSE_NONE);
      pkt(h, 11'h001, 1, TLPC_CAUSE_DIGEST);
      pkt(mk(7'h00, 10'h001, 8'h0F, 10'h0), 11'h001, 1, TLPC_CAUSE_DIGEST);
      chk("stat_fwd_count", 16'h0002, fwd_cnt);
      chk("stat_mal_count", 16'h0002, mal_cnt);
      $display("t_digest done");
   endtask

   task automatic t_iocfg();
      logic [127:0] h;
      logic [6:0] ft [3] = '{7'h02, 7'h04, 7'h05};
      int pos [3] = '{116, 108, 106};
      tlpc_cause_t c;
      for (int t = 0; t < 3; t++) begin
         c = (t == 0) ? TLPC_CAUSE_IO : TLPC_CAUSE_CFG;
         pkt(mk(ft[t], 10'h001, 8'h0F, 10'h0), 11'h000, 0, c);
         for (int f = 0; f < 5; f++) begin
            h = mk(ft[t], (f == 3) ? 10'h002 : 10'h001, (f == 4) ? 8'h1F : 8'h0F, 10'h0);
            if (f < 3) h[pos[f]] = 1'b1;
            pkt(h, 11'h000, 1, c);
         end
      end
      h = mk(7'h04, 10'h001, 8'h0F, 10'h0);
      h[50:48] = 3'h2;
      pkt(h, 11'h000, 1, TLPC_CAUSE_FUNC);
      h[50:48] = 3'h1;
      pkt(h, 11'h000, 0, TLPC_CAUSE_NONE);
      $display("t_iocfg done");
   endtask

   // awkward cases: last dw of a page, a full 1024 dw page, a read across the page
   task automatic t_cross();
      pkt(mk(7'h40, 10'h001, 8'h0F, 10'h3FF), 11'h001, 0, TLPC_CAUSE_NONE);
      pkt(mk(7'h40, 10'h002, 8'hFF, 10'h3FF), 11'h002, 1, TLPC_CAUSE_CROSS);
      pkt(mk(7'h40, 10'h000, 8'hFF, 10'h000), 11'h400, 0, TLPC_CAUSE_NONE);
      pkt(mk(7'h00, 10'h002, 8'hFF, 10'h3FF), 11'h000, 2, TLPC_CAUSE_NONE);
      $display("t_cross done");
   endtask

   task automatic t_tag_intx();
      logic [127:0] h;
      h = mk(7'h00, 10'h001, 8'h0F, 10'h0);
      h[79:72] = 8'h20;
      pkt(h, 11'h000, 1, TLPC_CAUSE_TAG);
      ext_tag = 1'b1;
      pkt(h, 11'h000, 0, TLPC_CAUSE_NONE);
      h = mk(7'h30, 10'h000, 8'h20, 10'h0);
      pkt(h, 11'h000, 1, TLPC_CAUSE_INTX);
      dn_port = 1'b1;
      pkt(h, 11'h000, 0, TLPC_CAUSE_NONE);
      $display("t_tag_intx done");
   endtask

   task automatic t_be();
      pkt(mk(7'h00, 10'h002, 8'hF0, 10'h0), 11'h000, 2, TLPC_CAUSE_NONE);
      pkt(mk(7'h00, 10'h001, 8'h1F, 10'h0), 11'h000, 2, TLPC_CAUSE_NONE);
      pkt(mk(7'h00, 10'h002, 8'h0F, 10'h0), 11'h000, 2, TLPC_CAUSE_NONE);
      pkt(mk(7'h00, 10'h003, 8'hF1, 10'h0), 11'h000, 2, TLPC_CAUSE_NONE);
      pkt(mk(7'h00, 10'h002, 8'h11, 10'h0), 11'h000, 0, TLPC_CAUSE_NONE);
      pkt(mk(7'h00, 10'h003, 8'h7E, 10'h0), 11'h000, 0, TLPC_CAUSE_NONE);
      $display("t_be done");
   endtask

   // application stalls: both slots fill, then the link side is refused
   task automatic t_stall_tx();
      app_ready = 1'b0;
      rx_valid = 1'b1;
      rx_hdr = mk(7'h00, 10'h001, 8'h0F, 10'h0);
      repeat (4) @(posedge core_clk);
      #1;
      chk("rx_ready", 0, rx_ready);
      chk("app_valid", 1, app_valid);
      app_ready = 1'b1;
      @(posedge core_clk);
      #1;
      rx_valid = 1'b0;
      tx_valid = 1'b1;
      tx_hdr = mk(7'h02, 10'h002, 8'h0F, 10'h0);
      @(posedge core_clk);
      #1;
      tx_hdr = mk(7'h02, 10'h001, 8'h0F, 10'h0);
      chk("tx_chk_bad", 1, tx_bad);
      @(posedge core_clk);
      #1;
      tx_valid = 1'b0;
      chk("tx_chk_done", 1, tx_done);
      chk("tx_chk_bad", 0, tx_bad);
      @(posedge core_clk);
      #1;
      chk("app_valid", 0, app_valid);
      chk("tx_chk_done", 0, tx_done);
      $display("t_stall_tx done");
   endtask

   initial begin
      repeat (2) @(posedge core_clk);
      #1;
      srst = 1'b0;
      @(posedge core_clk);
      #1;
      t_digest();
      t_iocfg();
      t_cross();
      t_tag_intx();
      t_be();
      t_stall_tx();
      test_done();
   end

   // about 90 cycles are expected, so 2000 gives ample margin
   initial begin
      #20000;
      err_total++;
      test_done();
   end
endmodule

`default_nettype wire
